// File: test_user_otp_program_and_margin_check.sv
// Testbench for the user OTP program and check block
`timescale 1ns/1ps
`include "uop_defs.svh"
module test_user_otp_program_and_margin_check;
    logic clk_sys = 1'b0, rst_n = 1'b0, init_done_lock = 1'b0, mirror_wr = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, ctrl_value, rd;
    logic       reg_wr, reg_rd, pos_clear, pos_seen = 1'b0;
    logic [1:0] mirror_region = 2'h0, shared_base, prog_skip = 2'h0;
    logic [2:0] region_lock, fail_kind = 3'h0;
    uop_pkg::uop_req_s otp_req;
    uop_pkg::uop_rsp_s otp_rsp = '0;
    logic [4:0] op_log[$];
    int errors = 0, cmp_count = 0, cycles = 0, fail_idx = -1, cnt = 0;
    always #2.5 clk_sys = ~clk_sys;
    uop_host_model HOST (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    uop_otp_ctrl DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .init_done_lock(init_done_lock),
        .mirror_wr(mirror_wr), .mirror_region(mirror_region), .shared_base(shared_base),
        .otp_req(otp_req), .otp_rsp(otp_rsp), .region_lock(region_lock), .pos_clear(pos_clear),
        .ctrl_value(ctrl_value));
    // OTP engine stand-in: answers after three cycles, faults one chosen step
    always @(negedge clk_sys) begin
        otp_rsp = '0;
        if (cnt > 0) begin
            cnt--;
            if (cnt == 0) begin
                otp_rsp.done = 1'b1;
                if (op_log.size() - 1 == fail_idx)
                    {otp_rsp.ecc_dbl, otp_rsp.crc_bad, otp_rsp.mismatch} = fail_kind;
            end
        end
        if (otp_req.valid === 1'b1) begin
            op_log.push_back({otp_req.op, otp_req.region});
            if (otp_req.op === uop_pkg::UOP_OP_PROG)
                prog_skip = {otp_req.skip_link, otp_req.skip_pos};
            cnt = 3;
        end
        if (pos_clear === 1'b1)
            pos_seen = 1'b1;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
        HOST.read_reg(addr, rd);
        chk(what, exp, rd);
    endtask
    // Lets any unwanted extra request show up before the count is taken
    task automatic wait_ops(input int n);
        for (int i = 0; i < 300 && op_log.size() < n; i++)
            @(negedge clk_sys);
        repeat (12) @(negedge clk_sys);
        chk("op count", 8'(n), 8'(op_log.size()));
    endtask
    task automatic mirror(input logic [1:0] rg, input logic [1:0] exp);
        @(negedge clk_sys);
        mirror_wr = 1'b1;
        mirror_region = rg;
        @(negedge clk_sys);
        mirror_wr = 1'b0;
        @(negedge clk_sys);
        chk("shared base", 8'(exp), 8'(shared_base));
    endtask
    task automatic prog(input logic [7:0] w, input logic [1:0] rg, input int n, input logic [1:0] sk);
        uop_pkg::uop_op_e seq[3] = '{uop_pkg::UOP_OP_CRC, uop_pkg::UOP_OP_PROG, uop_pkg::UOP_OP_LOAD};
        op_log.delete();
        pos_seen = 1'b0;
        HOST.write_reg(`UOP_ADDR_CTRL, w);
        wait_ops(n);
        for (int i = 0; i < n; i++)
            chk("program op", 8'({seq[i], rg}), 8'(op_log[i]));
        if (n > 0)
            chk("skip bits", 8'(sk), 8'(prog_skip));
        chk("position cleared", 8'(sk[0]), 8'(pos_seen));
        rd_chk("control", `UOP_ADDR_CTRL, w);
        $display("program test %h done, errors %0d", w, errors);
    endtask
    task automatic run_check(input int idx, input logic [2:0] kind, input int n, input logic [7:0] st);
        uop_pkg::uop_op_e seq[3] = '{uop_pkg::UOP_OP_READ, uop_pkg::UOP_OP_LOW, uop_pkg::UOP_OP_HIGH};
        logic [1:0] rgs[3] = '{`UOP_RGN_UA2, `UOP_RGN_UA0, `UOP_RGN_UA1};
        fail_idx = idx;
        fail_kind = kind;
        op_log.delete();
        rd_chk("status idle", `UOP_ADDR_STAT, 8'h00);
        HOST.write_reg(`UOP_ADDR_CTRL, 8'h40);
        rd_chk("status running", `UOP_ADDR_STAT, 8'h02);
        wait_ops(n);
        for (int i = 0; i < n; i++)
            chk("check op", 8'({seq[i % 3], rgs[i / 3]}), 8'(op_log[i]));
        rd_chk("control after check", `UOP_ADDR_CTRL, 8'h00);
        rd_chk("status result", `UOP_ADDR_STAT, st);
        rd_chk("status after read", `UOP_ADDR_STAT, 8'h00);
        $display("check test %0d done, errors %0d", idx, errors);
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        rd_chk("control reset", `UOP_ADDR_CTRL, `UOP_CTRL_RST);
        rd_chk("unmapped", 8'h20, 8'h00);
        chk("lock reset", 8'h00, 8'(region_lock));
        run_check(-1, 3'h0, 1, 8'h01);
        prog(8'h83, `UOP_RGN_RSV, 0, 2'h0);
        mirror(`UOP_RGN_UA1, 2'h1);
        mirror(`UOP_RGN_UA2, 2'h1);
        mirror(`UOP_RGN_UA0, 2'h0);
        prog(8'h8e, `UOP_RGN_UA2, 3, 2'h3);
        chk("lock two", 8'h04, 8'(region_lock));
        chk("control copy", 8'h8e, ctrl_value);
        prog(8'h82, `UOP_RGN_UA2, 0, 2'h0);
        prog(8'hcc, `UOP_RGN_UA0, 2, 2'h0);
        prog(8'h81, `UOP_RGN_UA1, 2, 2'h0);
        chk("all locked", 8'h07, 8'(region_lock));
        run_check(-1, 3'h0, 9, 8'h00);
        run_check(0, 3'h2, 1, 8'h01);
        run_check(4, 3'h1, 5, 8'h01);
        run_check(8, 3'h4, 9, 8'h01);
        HOST.write_reg(`UOP_ADDR_STAT, 8'hff);
        rd_chk("status read only", `UOP_ADDR_STAT, 8'h00);
        init_done_lock = 1'b1;
        op_log.delete();
        HOST.write_reg(`UOP_ADDR_CTRL, 8'h40);
        wait_ops(0);
        rd_chk("control locked", `UOP_ADDR_CTRL, 8'h00);
        $display("lock test done, errors %0d", errors);
        close_out();
    end
endmodule

// File: uop_defs.svh
// Register offsets, field positions, reset values and timing figures
`ifndef UOP_DEFS_SVH
`define UOP_DEFS_SVH
`define UOP_ADDR_CTRL   8'h11
`define UOP_ADDR_STAT   8'h06
`define UOP_CTRL_RST    8'h00
`define UOP_STAT_RST    8'h00
`define UOP_BIT_TRIG    7
`define UOP_BIT_CHK     6
`define UOP_BIT_SKIPL   3
`define UOP_BIT_SKIPP   2
`define UOP_SEL_HI      1
`define UOP_SEL_LO      0
`define UOP_BIT_ACT     1
`define UOP_BIT_FAIL    0
`define UOP_RGN_UA0     2'h0
`define UOP_RGN_UA1     2'h1
`define UOP_RGN_UA2     2'h2
`define UOP_RGN_RSV     2'h3
`define UOP_CHK_LAST    4'h8
`define UOP_PRG_LAST    4'h2
`define UOP_CHK_WAIT_US 1500
`endif

// File: uop_host_model.sv
// Host controller model driving the register access strobes
`timescale 1ns/1ps
module uop_host_model (
    // Clock
    input  wire logic       clk_sys,
    // Register access
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // One-cycle strobe off the falling edge; bus inverted once released
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_wdata = ~data;
    endtask
    // Read data is registered, so taken one cycle after the strobe
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_sys);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        reg_addr = ~addr;
        data = reg_rdata;
    endtask
endmodule

// File: uop_otp_ctrl.sv
// User OTP program sequencer and margin check-read engine
`timescale 1ns/1ps
`include "uop_defs.svh"

module uop_otp_ctrl (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Register access
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    // Device state
    input  wire logic             init_done_lock,
    // Mirror write tap
    input  wire logic             mirror_wr,
    input  wire logic [1:0]       mirror_region,
    output logic      [1:0]       shared_base,
    // OTP array engine
    output uop_pkg::uop_req_s     otp_req,
    input  wire uop_pkg::uop_rsp_s otp_rsp,
    // Region state and control register copy
    output logic      [2:0]       region_lock,
    output logic                  pos_clear,
    output logic      [7:0]       ctrl_value
);
    uop_pkg::uop_st_e  st_r, st_nxt;
    uop_pkg::uop_req_s req_r, req_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [3:0] step_r, step_nxt;
    logic [1:0] base_r, base_nxt;
    logic [2:0] lock_r, lock_nxt;
    logic       chk_mode_r, chk_mode_nxt;
    logic       act_r, act_nxt;
    logic       fail_r, fail_nxt;
    logic       pclr_r, pclr_nxt;
    logic [1:0] prg_rgn_r, prg_rgn_nxt;
    logic       skl_r, skl_nxt;
    logic       skp_r, skp_nxt;
    logic       ctrl_wr;
    logic       start_chk;
    logic       start_prg;
    logic       chk_err;
    logic       chk_end;
    logic       prg_end;
    logic       fail_set;
    logic [1:0] cur_rgn;

    // Check order is area two, zero, one
    function automatic logic [1:0] chk_region(input logic [3:0] s);
        case (s)
            4'h0, 4'h1, 4'h2: chk_region = `UOP_RGN_UA2;
            4'h3, 4'h4, 4'h5: chk_region = `UOP_RGN_UA0;
            default:          chk_region = `UOP_RGN_UA1;
        endcase
    endfunction

    function automatic uop_pkg::uop_op_e chk_op(input logic [3:0] s);
        case (s)
            4'h0, 4'h3, 4'h6: chk_op = uop_pkg::UOP_OP_READ;
            4'h1, 4'h4, 4'h7: chk_op = uop_pkg::UOP_OP_LOW;
            default:          chk_op = uop_pkg::UOP_OP_HIGH;
        endcase
    endfunction

    function automatic uop_pkg::uop_op_e prg_op(input logic [3:0] s);
        case (s)
            4'h0:    prg_op = uop_pkg::UOP_OP_CRC;
            4'h1:    prg_op = uop_pkg::UOP_OP_PROG;
            default: prg_op = uop_pkg::UOP_OP_LOAD;
        endcase
    endfunction

    // Writes are inhibited once init-done is set, start included
    assign ctrl_wr   = reg_wr && reg_addr == `UOP_ADDR_CTRL && !init_done_lock;
    assign start_prg = ctrl_wr && st_r == uop_pkg::UOP_ST_IDLE
                       && reg_wdata[`UOP_BIT_TRIG]
                       && reg_wdata[`UOP_SEL_HI:`UOP_SEL_LO] != `UOP_RGN_RSV
                       && !lock_r[reg_wdata[`UOP_SEL_HI:`UOP_SEL_LO]];
    assign start_chk = ctrl_wr && st_r == uop_pkg::UOP_ST_IDLE
                       && reg_wdata[`UOP_BIT_CHK] && !start_prg;
    assign cur_rgn   = chk_mode_r ? chk_region(step_r) : prg_rgn_r;

    // Plain read adds CRC and lock; margin reads add compare
    always_comb begin
        chk_err = otp_rsp.ecc_dbl;
        if (chk_op(step_r) == uop_pkg::UOP_OP_READ) begin
            chk_err = chk_err || otp_rsp.crc_bad || !lock_r[cur_rgn];
        end else begin
            chk_err = chk_err || otp_rsp.mismatch;
        end
    end

    assign chk_end  = st_r == uop_pkg::UOP_ST_WAIT && chk_mode_r && otp_rsp.done
                      && (chk_err || step_r == `UOP_CHK_LAST);
    assign fail_set = chk_end && chk_err;
    assign prg_end  = st_r == uop_pkg::UOP_ST_WAIT && !chk_mode_r && otp_rsp.done
                      && (step_r == `UOP_PRG_LAST
                          || (step_r == 4'h1 && prg_rgn_r != `UOP_RGN_UA2));

    always_comb begin
        st_nxt       = st_r;
        req_nxt      = req_r;
        req_nxt.valid = 1'b0;
        ctrl_nxt     = ctrl_r;
        step_nxt     = step_r;
        base_nxt     = base_r;
        lock_nxt     = lock_r;
        chk_mode_nxt = chk_mode_r;
        act_nxt      = act_r;
        fail_nxt     = fail_r;
        pclr_nxt     = 1'b0;
        prg_rgn_nxt  = prg_rgn_r;
        skl_nxt      = skl_r;
        skp_nxt      = skp_r;
        rdata_nxt    = rdata_r;
        // Shared block follows the last area zero or one region written
        if (mirror_wr && mirror_region != `UOP_RGN_UA2
            && mirror_region != `UOP_RGN_RSV) begin
            base_nxt = mirror_region;
        end
        // Mid-check writes keep the check start bit, no relaunch
        if (ctrl_wr) begin
            ctrl_nxt = reg_wdata;
            if (st_r != uop_pkg::UOP_ST_IDLE && chk_mode_r) begin
                ctrl_nxt[`UOP_BIT_CHK] = 1'b1;
            end
        end
        if (reg_rd) begin
            case (reg_addr)
                `UOP_ADDR_CTRL: rdata_nxt = ctrl_r;
                `UOP_ADDR_STAT: rdata_nxt = {6'h00, act_r, fail_r};
                default:        rdata_nxt = 8'h00;
            endcase
            if (reg_addr == `UOP_ADDR_STAT && !act_r) begin
                fail_nxt = 1'b0;
            end
        end
        case (st_r)
            uop_pkg::UOP_ST_IDLE: begin
                if (start_prg) begin
                    chk_mode_nxt = 1'b0;
                    step_nxt     = 4'h0;
                    prg_rgn_nxt  = reg_wdata[`UOP_SEL_HI:`UOP_SEL_LO];
                    // Exclusions only act on area two
                    skl_nxt = reg_wdata[`UOP_BIT_SKIPL] && prg_rgn_nxt == `UOP_RGN_UA2;
                    skp_nxt = reg_wdata[`UOP_BIT_SKIPP] && prg_rgn_nxt == `UOP_RGN_UA2;
                    st_nxt  = uop_pkg::UOP_ST_ISSUE;
                end else if (start_chk) begin
                    chk_mode_nxt = 1'b1;
                    step_nxt     = 4'h0;
                    act_nxt      = 1'b1;
                    st_nxt       = uop_pkg::UOP_ST_ISSUE;
                end
            end
            uop_pkg::UOP_ST_ISSUE: begin
                req_nxt.valid     = 1'b1;
                req_nxt.op        = chk_mode_r ? chk_op(step_r) : prg_op(step_r);
                req_nxt.region    = cur_rgn;
                req_nxt.skip_link = !chk_mode_r && skl_r;
                req_nxt.skip_pos  = !chk_mode_r && skp_r;
                st_nxt            = uop_pkg::UOP_ST_WAIT;
            end
            uop_pkg::UOP_ST_WAIT: begin
                if (otp_rsp.done) begin
                    if (!chk_mode_r && step_r == 4'h1) begin
                        lock_nxt[prg_rgn_r] = 1'b1;
                        pclr_nxt = skp_r;
                    end
                    if (chk_end) begin
                        act_nxt  = 1'b0;
                        ctrl_nxt[`UOP_BIT_CHK] = 1'b0;
                        st_nxt   = uop_pkg::UOP_ST_IDLE;
                    end else if (prg_end) begin
                        // Trigger bit is left set
                        st_nxt = uop_pkg::UOP_ST_IDLE;
                    end else begin
                        step_nxt = step_r + 4'h1;
                        st_nxt   = uop_pkg::UOP_ST_ISSUE;
                    end
                end
            end
            default: begin
                st_nxt = uop_pkg::UOP_ST_IDLE;
            end
        endcase
        // Failure set wins over a same-cycle read clear
        if (fail_set) begin
            fail_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r       <= uop_pkg::UOP_ST_IDLE;
            req_r      <= '0;
            ctrl_r     <= `UOP_CTRL_RST;
            rdata_r    <= 8'h00;
            step_r     <= 4'h0;
            base_r     <= `UOP_RGN_UA0;
            lock_r     <= 3'h0;
            chk_mode_r <= 1'b0;
            act_r      <= 1'b0;
            fail_r     <= 1'b0;
            pclr_r     <= 1'b0;
            prg_rgn_r  <= `UOP_RGN_UA0;
            skl_r      <= 1'b0;
            skp_r      <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            req_r      <= req_nxt;
            ctrl_r     <= ctrl_nxt;
            rdata_r    <= rdata_nxt;
            step_r     <= step_nxt;
            base_r     <= base_nxt;
            lock_r     <= lock_nxt;
            chk_mode_r <= chk_mode_nxt;
            act_r      <= act_nxt;
            fail_r     <= fail_nxt;
            pclr_r     <= pclr_nxt;
            prg_rgn_r  <= prg_rgn_nxt;
            skl_r      <= skl_nxt;
            skp_r      <= skp_nxt;
        end
    end

    // Mirror writes reach only the mirror; cells move on otp_req alone
    assign otp_req     = req_r;
    assign reg_rdata   = rdata_r;
    assign shared_base = base_r;
    assign region_lock = lock_r;
    assign pos_clear   = pclr_r;
    assign ctrl_value  = ctrl_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_start_sets_active: assert property (start_chk |=> act_r && ctrl_r[`UOP_BIT_CHK])
        else $error("check start did not raise active");
    a_first_is_area2: assert property (start_chk |-> ##2 (otp_req.valid
        && otp_req.region == `UOP_RGN_UA2 && otp_req.op == uop_pkg::UOP_OP_READ))
        else $error("check did not begin with area two read");
    a_err_stops_test: assert property (fail_set |=> st_r == uop_pkg::UOP_ST_IDLE && fail_r && !act_r)
        else $error("check error did not stop with fail");
    a_low_follows_read: assert property (st_r == uop_pkg::UOP_ST_WAIT && chk_mode_r && otp_rsp.done && !chk_err
        && chk_op(step_r) == uop_pkg::UOP_OP_READ |-> ##2 (otp_req.valid
        && otp_req.op == uop_pkg::UOP_OP_LOW && otp_req.region == $past(cur_rgn, 2)))
        else $error("low margin read did not follow read");
    a_end_clears_bit: assert property (chk_end |=> !ctrl_r[`UOP_BIT_CHK] && !act_r)
        else $error("start bit not cleared at end");
    a_lock_blocks_wr: assert property (reg_wr && reg_addr == `UOP_ADDR_CTRL && init_done_lock
        && st_r == uop_pkg::UOP_ST_IDLE |=> $stable(ctrl_r) && st_r == uop_pkg::UOP_ST_IDLE)
        else $error("write taken under init-done lock");
    a_read_clears_fail: assert property (reg_rd && reg_addr == `UOP_ADDR_STAT && !act_r
        && !fail_set |=> !fail_r)
        else $error("status read did not clear fail");
    a_prog_locks_rgn: assert property (st_r == uop_pkg::UOP_ST_WAIT && !chk_mode_r
        && step_r == 4'h1 && otp_rsp.done |=> lock_r[prg_rgn_r])
        else $error("region not locked after program");
    a_no_locked_prog: assert property (otp_req.valid && otp_req.op == uop_pkg::UOP_OP_PROG
        |-> !lock_r[otp_req.region])
        else $error("program issued to locked region");
    a_trig_stays_set: assert property (ctrl_r[`UOP_BIT_TRIG] && !ctrl_wr |=> ctrl_r[`UOP_BIT_TRIG])
        else $error("trigger bit dropped");
    a_area2_reload: assert property (st_r == uop_pkg::UOP_ST_WAIT && !chk_mode_r && step_r == 4'h1
        && otp_rsp.done && prg_rgn_r == `UOP_RGN_UA2 |-> ##2 (otp_req.valid
        && otp_req.op == uop_pkg::UOP_OP_LOAD))
        else $error("area two not reloaded");

    c_check_pass: cover property (chk_end && !chk_err);
    c_check_fail: cover property (fail_set);
    c_prog_area2: cover property (prg_end && prg_rgn_r == `UOP_RGN_UA2 && skp_r);
    c_prog_area0: cover property (prg_end && prg_rgn_r == `UOP_RGN_UA0);
endmodule

// File: uop_pkg.sv
// Types shared by the user OTP program and check block
package uop_pkg;
    typedef enum logic [2:0] {
        UOP_OP_READ, UOP_OP_LOW, UOP_OP_HIGH,
        UOP_OP_CRC, UOP_OP_PROG, UOP_OP_LOAD
    } uop_op_e;
    typedef enum logic [1:0] {
        UOP_ST_IDLE, UOP_ST_ISSUE, UOP_ST_WAIT
    } uop_st_e;
    typedef struct packed {
        logic    valid;
        uop_op_e op;
        logic [1:0] region;
        logic    skip_link;
        logic    skip_pos;
    } uop_req_s;
    typedef struct packed {
        logic done;
        logic ecc_dbl;
        logic crc_bad;
        logic mismatch;
    } uop_rsp_s;
endpackage
